/* hdl/sar_adc_ctrl.sv */
// Control logic of a muxed 8-bit successive-approximation converter
// Behaviour
// - CS low, WR rising: load new channel setup, start conversion.
// - CS and RD low: drive result, restart, keep channel setup.
// - A write may follow a read at once; it is accepted.
// - Negative sample follows positive by half a clock period.
// - Comparator decision latched at end of each clock period.
// - Span divided into 256 equal code steps.
// - Equal inputs give the all-zero code.
// - First transition at half a code step.
// - Last transition one and a half steps below full scale.
// - Positive below negative gives all-zero code.
// - WR rising with RD high latches the five select lines.
// - CS and RD low clear the done flag and drive the result.
// - Single-ended: channel positive, analog ground negative.
`timescale 1ns/1ps
module sar_adc_ctrl (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Microprocessor bus pins
    input wire logic cs_n_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    input wire logic [sar_pkg::SEL_W-1:0] mux_sel_lines_i,
    // Analog channels as codes, plus analog ground
    input wire logic [sar_pkg::CHAN_N*sar_pkg::CODE_W-1:0] chan_i,
    input wire logic [sar_pkg::CODE_W-1:0] analog_ground_input_i,
    // Result and completion
    output logic [sar_pkg::CODE_W-1:0] result_bus_o,
    output logic result_bus_oe_n_o,
    output logic conv_done_n_o
);
    import sar_pkg::*;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_POS,
        ST_NEG
    } seq_state_type;

    logic rst_s1_q, rst_s2_q, rst_n;
    logic [2:0] cs_sync_q, wr_sync_q, rd_sync_q;
    logic cs_n, wr_n, rd_n, wr_prev_q, rd_prev_q;
    logic [SEL_W-1:0] sel_s1_q, sel_s2_q, sel_q;
    logic wr_fall, wr_rise, rd_start;
    seq_state_type state_q;
    logic [15:0] cnt_q;
    logic [CHAN_W-1:0] bit_q;
    logic [CODE_W-1:0] sar_q, result_q;
    logic [CODE_W:0] trial;
    logic done_n_q, oe_n_q, start, apply_q;
    mux_mode_type mode;
    logic [CHAN_W-1:0] pos_ch, neg_ch;
    logic [CODE_W-1:0] vpos, vneg;
    logic pos_end, neg_end;

    sar_step_if step ();

    // Reset release through two stages
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // Strobe pins pass three stages, select pins two; a strobe change counts when stages two and three agree
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_q <= 3'h7;
            wr_sync_q <= 3'h7;
            rd_sync_q <= 3'h7;
            cs_n <= 1'b1;
            wr_n <= 1'b1;
            rd_n <= 1'b1;
            sel_s1_q <= SEL_RESET;
            sel_s2_q <= SEL_RESET;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], cs_n_i};
            wr_sync_q <= {wr_sync_q[1:0], wr_n_i};
            rd_sync_q <= {rd_sync_q[1:0], rd_n_i};
            sel_s1_q <= mux_sel_lines_i;
            sel_s2_q <= sel_s1_q;
            if (cs_sync_q[1] == cs_sync_q[2]) begin
                cs_n <= cs_sync_q[2];
            end
            if (wr_sync_q[1] == wr_sync_q[2]) begin
                wr_n <= wr_sync_q[2];
            end
            if (rd_sync_q[1] == rd_sync_q[2]) begin
                rd_n <= rd_sync_q[2];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
        end else begin
            wr_prev_q <= wr_n;
            rd_prev_q <= rd_n;
        end
    end

    assign wr_fall = wr_prev_q && !wr_n && !cs_n;
    assign wr_rise = !wr_prev_q && wr_n && !cs_n;
    // Read start only when RD low begins under CS
    assign rd_start = rd_prev_q && !rd_n && !cs_n;

    // latch select on WR rising, RD high
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= SEL_RESET;
        end else if (wr_rise && rd_n) begin
            sel_q <= sel_s2_q;
        end
    end

    // select decode into mode and pair
    always_comb begin
        mode = MODE_DIFF;
        pos_ch = sel_q[2:0];
        neg_ch = sel_q[2:0];
        if (!sel_q[3]) begin
            mode = MODE_DIFF;
            pos_ch = {sel_q[2:1], sel_q[0]};
            neg_ch = {sel_q[2:1], ~sel_q[0]};
        end else if (!sel_q[4]) begin
            mode = MODE_SINGLE;
        end else begin
            mode = MODE_PSEUDO;
            neg_ch = 3'h7;
        end
    end

    assign vpos = chan_i[pos_ch*CODE_W +: CODE_W];
    assign vneg = (mode == MODE_SINGLE) ? analog_ground_input_i
        : chan_i[neg_ch*CODE_W +: CODE_W];

    assign start = (wr_rise && rd_n) || rd_start;

    assign pos_end = (state_q == ST_POS) && (cnt_q == 16'(HALF_PERIOD_CYC-1));
    assign neg_end = (state_q == ST_NEG) && (cnt_q == 16'(HALF_PERIOD_CYC-1));
    assign step.sample_pos = pos_end;
    assign step.sample_neg = neg_end;
    assign step.strobe = neg_end;

    // trial level in 256 steps, doubled
    assign trial = {sar_q | (8'h80 >> bit_q), 1'b0} - 9'h001;

    sar_comparator u_cmp (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .vin_pos_i(vpos),
        .vin_neg_i(vneg),
        .trial_i(trial),
        .step(step)
    );

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 3'h0;
            sar_q <= CODE_ZERO;
        end else if (start) begin
            // A new start restarts the sequence at once
            state_q <= ST_POS;
            cnt_q <= 16'h0000;
            bit_q <= 3'h0;
            sar_q <= CODE_ZERO;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    cnt_q <= 16'h0000;
                end
                ST_POS: begin
                    cnt_q <= pos_end ? 16'h0000 : cnt_q + 16'h0001;
                    if (pos_end) begin
                        state_q <= ST_NEG;
                    end
                end
                ST_NEG: begin
                    cnt_q <= neg_end ? 16'h0000 : cnt_q + 16'h0001;
                    if (neg_end) begin
                        // Last bit's strobe ends the sequence
                        state_q <= (bit_q == 3'h7) ? ST_IDLE : ST_POS;
                    end
                end
            endcase
            // Decision lands one cycle after the strobe
            if (apply_q) begin
                if (step.decide) begin
                    sar_q <= sar_q | (8'h80 >> bit_q);
                end
                bit_q <= bit_q + 3'h1;
            end
        end
    end

    // Decision applied one cycle after strobe, then next bit
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            apply_q <= 1'b0;
        end else begin
            apply_q <= neg_end && !start;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= RESULT_RESET;
            done_n_q <= 1'b1;
        end else begin
            if (rd_start || wr_fall) begin
                done_n_q <= 1'b1;
            end
            // Completion in the same cycle wins, so no result is lost
            if (apply_q) begin
                if (bit_q == 3'h7) begin
                    result_q <= sar_q | (step.decide ? 8'h01 : 8'h00);
                    done_n_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            oe_n_q <= 1'b1;
            result_bus_o <= RESULT_RESET;
        end else begin
            // drive result during CS and RD
            oe_n_q <= !( !cs_n && !rd_n );
            result_bus_o <= result_q;
        end
    end

    assign result_bus_oe_n_o = oe_n_q;
    assign conv_done_n_o = done_n_q;
endmodule : sar_adc_ctrl

/* hdl/sar_pkg.sv */
// Shared constants and types for the converter control block
package sar_pkg;
    localparam int CODE_W = 8;
    localparam int SEL_W = 5;
    localparam int CHAN_N = 8;
    localparam int CHAN_W = 3;
    // Internal conversion clock period, in ns
    localparam int CONV_CLK_NS = 800;
    localparam int SYS_CLK_NS = 4;
    localparam int HALF_PERIOD_CYC = (CONV_CLK_NS / 2) / SYS_CLK_NS;
    localparam int PERIOD_CYC = 2 * HALF_PERIOD_CYC;
    // Full-span code count, end codes and reset values
    localparam int CODE_STEPS = 256;
    localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
    localparam logic [CODE_W-1:0] CODE_FULL = 8'hFF;
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
    localparam logic [CODE_W-1:0] RESULT_RESET = 8'h00;
    typedef enum logic [1:0] {
        MODE_DIFF,
        MODE_SINGLE,
        MODE_PSEUDO
    } mux_mode_type;
endpackage : sar_pkg

/* hdl/sar_step_if.sv */
// Handshake between sequencer and per-bit comparator sampler
`timescale 1ns/1ps
interface sar_step_if;
    import sar_pkg::*;
    logic sample_pos;
    logic sample_neg;
    logic strobe;
    logic decide;
    modport ctl (output sample_pos, output sample_neg, output strobe,
        input decide);
    modport cmp (input sample_pos, input sample_neg, input strobe,
        output decide);
endinterface : sar_step_if

/* hdl/sar_comparator.sv */
// Sampled-data comparator: holds both samples, latches the decision
`timescale 1ns/1ps
module sar_comparator (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Analog stand-ins, as codes
    input wire logic [sar_pkg::CODE_W-1:0] vin_pos_i,
    input wire logic [sar_pkg::CODE_W-1:0] vin_neg_i,
    input wire logic [sar_pkg::CODE_W:0] trial_i,
    // Sequencer side
    sar_step_if.cmp step
);
    import sar_pkg::*;
    logic [CODE_W-1:0] pos_q;
    logic [CODE_W-1:0] neg_q;
    logic decide_q;
    logic [CODE_W-1:0] neg_now;
    // Strobe meets the negative sample in the same cycle
    assign neg_now = step.sample_neg ? vin_neg_i : neg_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_q <= CODE_ZERO;
            neg_q <= CODE_ZERO;
        end else begin
            if (step.sample_pos) begin
                pos_q <= vin_pos_i;
            end
            if (step.sample_neg) begin
                neg_q <= vin_neg_i;
            end
        end
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            decide_q <= 1'b0;
        end else if (step.strobe) begin
            decide_q <= ({1'b0, pos_q, 1'b0} >= ({neg_now, 1'b0} + {1'b0,
                trial_i}));
        end
    end
    assign step.decide = decide_q;
endmodule : sar_comparator

/* verif/sar_adc_ctrl_checker.sv */
// Port-level checks of the converter control block
`timescale 1ns/1ps
module sar_adc_ctrl_checker
    import sar_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Bus strobes
    input wire logic cs_n_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    // Watched outputs
    input wire logic [sar_pkg::CODE_W-1:0] result_bus_o,
    input wire logic result_bus_oe_n_o,
    input wire logic conv_done_n_o
);
    // Margins cover strobe sync and release lag
    localparam int DONE_MIN = 8 * PERIOD_CYC - 20;
    localparam int DONE_MAX = 8 * PERIOD_CYC + 60;
    logic strobe_on;
    logic rd_sel;
    logic [15:0] quiet_q;
    logic pend_q;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    assign rd_sel = !cs_n_i && !rd_n_i;
    assign strobe_on = rd_sel || (!cs_n_i && !wr_n_i);
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            quiet_q <= 16'h0000;
        end else if (strobe_on) begin
            quiet_q <= 16'h0000;
        end else if (quiet_q != 16'hFFFF) begin
            quiet_q <= quiet_q + 16'h0001;
        end
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= 1'b0;
        end else if (strobe_on) begin
            pend_q <= 1'b1;
        end else if (!conv_done_n_o) begin
            pend_q <= 1'b0;
        end
    end
    chk_oe_read_cause: assert property (
        $fell(result_bus_oe_n_o) |-> $past(rd_sel)) else $error("oe no read");
    chk_oe_idle_cs: assert property (
        cs_n_i [*6] |-> result_bus_oe_n_o) else $error("oe while idle");
    chk_read_clears_done: assert property (
        !result_bus_oe_n_o ##1 !result_bus_oe_n_o |-> conv_done_n_o)
        else $error("done low in read");
    chk_read_data_stable: assert property (
        !result_bus_oe_n_o ##1 !result_bus_oe_n_o |-> $stable(result_bus_o))
        else $error("data moved in read");
    chk_done_holds: assert property (
        (cs_n_i [*6]) ##0 !conv_done_n_o |=> !conv_done_n_o)
        else $error("done dropped");
    chk_done_not_early: assert property (
        $fell(conv_done_n_o) |-> quiet_q >= DONE_MIN) else $error("done early");
    chk_done_in_time: assert property (
        pend_q |-> quiet_q <= DONE_MAX) else $error("done late");
    chk_reset_idle_out: assert property (
        $rose(rst_n_i) |-> conv_done_n_o && result_bus_oe_n_o
        && result_bus_o == RESULT_RESET) else $error("bad reset state");
    cover property ($fell(conv_done_n_o));
    cover property ($fell(result_bus_oe_n_o));
    cover property (!cs_n_i && !wr_n_i);
endmodule : sar_adc_ctrl_checker

bind sar_adc_ctrl sar_adc_ctrl_checker i_chk (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i),
    .result_bus_o(result_bus_o), .result_bus_oe_n_o(result_bus_oe_n_o),
    .conv_done_n_o(conv_done_n_o));

/* verif/host_bus_model.sv */
// Behavioural host bus master for the converter strobes
`timescale 1ns/1ps
module host_bus_model
    import sar_pkg::*;
(
    // Clock
    input wire logic clk_sys_i,
    // Strobes and select lines
    output logic cs_n_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic [sar_pkg::SEL_W-1:0] sel_o,
    // Converter outputs
    input wire logic [sar_pkg::CODE_W-1:0] data_i,
    input wire logic oe_n_i
);
    // Strobes cross a synchroniser, so each write phase lasts 6 cycles and a read 8
    localparam int HOLD_CYC = 6;
    initial begin
        cs_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        sel_o = 5'h1F;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step
    task automatic bus_write(input logic [SEL_W-1:0] sel);
        step(1);
        cs_n_o = 1'b0;
        sel_o = sel;
        wr_n_o = 1'b0;
        step(HOLD_CYC);
        wr_n_o = 1'b1;
        step(HOLD_CYC);
        cs_n_o = 1'b1;
        // Shared lines float with no pull: show a changed pattern
        sel_o = ~sel;
    endtask : bus_write
    task automatic bus_read(output logic [CODE_W-1:0] data, output logic oe);
        step(1);
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        step(HOLD_CYC + 2);
        data = data_i;
        oe = oe_n_i;
        rd_n_o = 1'b1;
        cs_n_o = 1'b1;
    endtask : bus_read
endmodule : host_bus_model

/* verif/tb_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
    import sar_pkg::*;
    logic clk_sys_i, rst_n_i, cs_n, wr_n, rd_n, oe_n, done_n;
    logic [SEL_W-1:0] sel;
    logic [CODE_W-1:0] result;
    logic [CHAN_N*CODE_W-1:0] chan = 64'hA0A0_FF00_FF3C_1090;
    logic [CODE_W-1:0] gnd = 8'h05;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    sar_adc_ctrl i_sar_adc_ctrl (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n), .mux_sel_lines_i(sel),
        .chan_i(chan), .analog_ground_input_i(gnd), .result_bus_o(result),
        .result_bus_oe_n_o(oe_n), .conv_done_n_o(done_n));
    host_bus_model i_host_bus_model (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n),
        .wr_n_o(wr_n), .rd_n_o(rd_n), .sel_o(sel), .data_i(result),
        .oe_n_i(oe_n));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // Conversion is about 1600 cycles; 2000 bounds the wait
    task automatic wait_done;
        int n = 0;
        while (done_n !== 1'b0 && n < 2000) begin
            @(posedge clk_sys_i);
            n++;
        end
        #1;
        check({7'h00, done_n}, 8'h00);
    endtask : wait_done
    task automatic read_check(input logic [CODE_W-1:0] exp);
        logic [CODE_W-1:0] d;
        logic oe;
        i_host_bus_model.bus_read(d, oe);
        check(d, exp);
        check({7'h00, oe}, 8'h00);
        check({7'h00, done_n}, 8'h01);
    endtask : read_check
    // Each case after the first written straight after the previous read
    task automatic sc_decode_table;
        logic [SEL_W-1:0] s [9] = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h06,
            5'h0A, 5'h0D, 5'h1D, 5'h18};
        logic [CODE_W-1:0] e [9] = '{8'h80, 8'h00, 8'hC3, 8'hFF, 8'h00,
            8'h37, 8'hFA, 8'h5F, 8'h00};
        for (int i = 0; i < 9; i++) begin
            i_host_bus_model.bus_write(s[i]);
            wait_done();
            read_check(e[i]);
        end
    endtask : sc_decode_table
    task automatic sc_read_restarts;
        wait_done();
        read_check(8'h00);
    endtask : sc_read_restarts
    task automatic sc_abort_write;
        i_host_bus_model.bus_write(5'h03);
        i_host_bus_model.step(500);
        check({7'h00, done_n}, 8'h01);
        i_host_bus_model.bus_write(5'h0A);
        wait_done();
        read_check(8'h37);
    endtask : sc_abort_write
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles >= 40000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        i_host_bus_model.step(5);
        sc_decode_table();
        sc_read_restarts();
        sc_abort_write();
        complete_run();
    end
endmodule : tb_top
